// ---- rtl/sdas_defs.vh ----
`ifndef SDAS_DEFS_VH
`define SDAS_DEFS_VH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define SDAS_ADDR_CTRL 4'h0
`define SDAS_ADDR_STAT 4'h4
`define SDAS_ADDR_MASK 4'h8
`define SDAS_ADDR_RSLT 4'hC

// ****************************************************************
// Control register fields
// ****************************************************************
`define SDAS_CTRL_START 0
`define SDAS_CTRL_STOP 1
`define SDAS_CTRL_MODE_LO 2
`define SDAS_CTRL_MODE_HI 3
`define SDAS_CTRL_RES8 4
`define SDAS_CTRL_SEL_LO 8
`define SDAS_CTRL_SEL_HI 11

// ****************************************************************
// Status register fields (done and overrun are sticky)
// ****************************************************************
`define SDAS_STAT_DONE 0
`define SDAS_STAT_OVR 1
`define SDAS_STAT_BUSY 2
`define SDAS_STAT_PRIMED 3
`define SDAS_IRQ_W 2

// ****************************************************************
// Modes, priming and decimation
// ****************************************************************
`define SDAS_MODE_SINGLE 2'h0
`define SDAS_MODE_MULTI 2'h1
`define SDAS_MODE_CONT 2'h2
`define SDAS_MODE_TURBO 2'h3
`define SDAS_PRIME_LAST 2'h3
`define SDAS_DEC12_M1 6'h3F
`define SDAS_DEC8_M1 6'h1F
`define SDAS_R12_SAT 24
`define SDAS_R12_HI 23
`define SDAS_R8_SAT 20
`define SDAS_R8_HI 19
`define SDAS_R_LO 12
`define SDAS_RESP_OKAY 2'h0
`define SDAS_RESP_SLVERR 2'h2

`endif

// ---- rtl/sdas_sticky.v ----
`timescale 1ns/1ns
`include "sdas_defs.vh"

module sdas_sticky #(
   parameter W = 2
) (
   input wire aclk,
   input wire aresetn,
   input wire [W-1:0] set,
   input wire [W-1:0] clr,
   output reg [W-1:0] flag_q
);

   // A set arriving together with its clear wins, so no event is lost.
   always @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= {W{1'b0}};
      end else begin
         flag_q <= set | (flag_q & ~clr);
      end
   end

endmodule

// ---- rtl/sdas_sinc4.v ----
`timescale 1ns/1ns
`include "sdas_defs.vh"

module sdas_sinc4 #(
   parameter ACC_W = 25,
   parameter CNT_W = 6
) (
   input wire aclk,
   input wire aresetn,
   input wire clear,
   input wire bit_in,
   input wire bit_valid,
   input wire [CNT_W-1:0] ratio_m1,
   output reg [ACC_W-1:0] out_word,
   output reg out_valid
);

   reg [ACC_W-1:0] integ_q [0:3];
   reg [ACC_W-1:0] dly_q [0:3];
   reg [ACC_W-1:0] stage [0:4];
   reg [CNT_W-1:0] dcnt_q;
   wire dec_tick;
   integer k;
   integer j;

   assign dec_tick = bit_valid && (dcnt_q == ratio_m1);

   // fourth-order sinc
   // Four integrators and four combs give the fourth-power sinc response.
   always @* begin
      stage[0] = integ_q[3];
      for (j = 0; j < 4; j = j + 1) begin
         stage[j+1] = stage[j] - dly_q[j];
      end
   end

   // A clear empties the whole pipeline so old samples leave no trace.
   always @(posedge aclk) begin
      if (!aresetn || clear) begin
         for (k = 0; k < 4; k = k + 1) begin
            integ_q[k] <= {ACC_W{1'b0}};
            dly_q[k] <= {ACC_W{1'b0}};
         end
         dcnt_q <= {CNT_W{1'b0}};
         out_word <= {ACC_W{1'b0}};
         out_valid <= 1'b0;
      end else begin
         out_valid <= dec_tick;
         if (bit_valid) begin
            integ_q[0] <= integ_q[0] + {{(ACC_W-1){1'b0}}, bit_in};
            for (k = 1; k < 4; k = k + 1) begin
               integ_q[k] <= integ_q[k] + integ_q[k-1];
            end
            dcnt_q <= dec_tick ? {CNT_W{1'b0}} : dcnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         if (dec_tick) begin
            for (k = 0; k < 4; k = k + 1) begin
               dly_q[k] <= stage[k];
            end
            out_word <= stage[4];
         end
      end
   end

endmodule

// ---- rtl/sdas_top.v ----
`timescale 1ns/1ns
`include "sdas_defs.vh"


module sdas_top #(
   parameter ACC_W = 25,
   parameter CNT_W = 6,
   parameter RES_W = 12,
   parameter SEL_W = 4
) (
   input wire aclk,
   input wire aresetn,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire mod_bit,
   input wire mod_bit_valid,
   input wire conv_start,
   output reg mod_en_q,
   output reg mod_rst_q,
   output reg [SEL_W-1:0] chan_sel_q,
   output wire conv_done,
   output reg irq_q
);

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_RUN = 3'b010;
   localparam [2:0] ST_HOLD = 3'b100;

   // ****************************************************************
   // Register bus
   // ****************************************************************
   reg [3:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg aw_have_q;
   reg w_have_q;
   reg [1:0] mode_q;
   reg res8_q;
   reg [`SDAS_IRQ_W-1:0] mask_q;
   reg [RES_W-1:0] result_q;
   wire wr_fire;
   wire ctrl_wr;
   wire start_wr;
   wire stop_wr;
   wire sel_wr;
   wire rd_result;
   wire [`SDAS_IRQ_W-1:0] flag_q;
   reg [31:0] rd_word;
   reg rd_ok;

   assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
   assign ctrl_wr = wr_fire && (awaddr_q == `SDAS_ADDR_CTRL);
   assign start_wr = ctrl_wr && wstrb_q[0] && wdata_q[`SDAS_CTRL_START];
   assign stop_wr = ctrl_wr && wstrb_q[0] && wdata_q[`SDAS_CTRL_STOP];
   assign sel_wr = ctrl_wr && wstrb_q[1] &&
      (wdata_q[`SDAS_CTRL_SEL_HI:`SDAS_CTRL_SEL_LO] != chan_sel_q);
   assign rd_result = s_axi_arvalid && s_axi_arready &&
      (s_axi_araddr == `SDAS_ADDR_RSLT);

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SDAS_RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q[1:0] == 2'h0) ? `SDAS_RESP_OKAY : `SDAS_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Mode, resolution, select and mask are held; start and stop are strobes.
   always @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= `SDAS_MODE_SINGLE;
         res8_q <= 1'b0;
         chan_sel_q <= {SEL_W{1'b0}};
         mask_q <= {`SDAS_IRQ_W{1'b0}};
      end else begin
         if (ctrl_wr && wstrb_q[0]) begin
            mode_q <= wdata_q[`SDAS_CTRL_MODE_HI:`SDAS_CTRL_MODE_LO];
            res8_q <= wdata_q[`SDAS_CTRL_RES8];
         end
         if (ctrl_wr && wstrb_q[1]) begin
            chan_sel_q <= wdata_q[`SDAS_CTRL_SEL_HI:`SDAS_CTRL_SEL_LO];
         end
         if (wr_fire && wstrb_q[0] && (awaddr_q == `SDAS_ADDR_MASK)) begin
            mask_q <= wdata_q[`SDAS_IRQ_W-1:0];
         end
      end
   end

   // ****************************************************************
   // Decimator and sequencer
   // ****************************************************************
   reg [2:0] state_q;
   reg [1:0] prime_q;
   reg dec_clr_q;
   reg new_res;
   wire [ACC_W-1:0] dec_word;
   wire dec_valid;
   wire trig;
   reg [RES_W-1:0] scaled;

   assign trig = start_wr || conv_start;

   sdas_sinc4 #(
      .ACC_W(ACC_W),
      .CNT_W(CNT_W)
   ) u_dec (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(dec_clr_q || !mod_en_q),
      .bit_in(mod_bit),
      .bit_valid(mod_bit_valid),
      .ratio_m1(res8_q ? `SDAS_DEC8_M1 : `SDAS_DEC12_M1),
      .out_word(dec_word),
      .out_valid(dec_valid)
   );

   // Full-scale input lands exactly on the next power of two, so saturate.
   always @* begin
      scaled = {RES_W{1'b0}};
      if (res8_q) begin
         scaled[RES_W-1:RES_W-8] = dec_word[`SDAS_R8_SAT] ? 8'hFF :
            dec_word[`SDAS_R8_HI:`SDAS_R_LO];
      end else begin
         scaled = dec_word[`SDAS_R12_SAT] ? {RES_W{1'b1}} :
            dec_word[`SDAS_R12_HI:`SDAS_R_LO];
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_IDLE;
         prime_q <= 2'h0;
         dec_clr_q <= 1'b0;
         mod_rst_q <= 1'b0;
         mod_en_q <= 1'b0;
         new_res <= 1'b0;
         result_q <= {RES_W{1'b0}};
      end else begin
         dec_clr_q <= 1'b0;
         mod_rst_q <= 1'b0;
         new_res <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               mod_en_q <= 1'b0;
               if (trig && !stop_wr) begin
                  state_q <= ST_RUN;
                  mod_en_q <= 1'b1;
                  mod_rst_q <= 1'b1;
                  dec_clr_q <= 1'b1;
                  prime_q <= 2'h0;
               end
            end
            ST_RUN: begin
               if (stop_wr) begin
                  state_q <= ST_IDLE;
                  mod_en_q <= 1'b0;
               end else if (sel_wr) begin
                  prime_q <= 2'h0;
               end else if (dec_valid && !dec_clr_q) begin
                  if (prime_q != `SDAS_PRIME_LAST) begin
                     prime_q <= prime_q + 2'h1;
                  end else begin
                     result_q <= scaled;
                     new_res <= 1'b1;
                     case (mode_q)
                        `SDAS_MODE_SINGLE: begin
                           state_q <= ST_HOLD;
                           mod_en_q <= 1'b0;
                        end
                        `SDAS_MODE_MULTI: begin
                           dec_clr_q <= 1'b1;
                           mod_rst_q <= 1'b1;
                           prime_q <= 2'h0;
                        end
                        `SDAS_MODE_TURBO: begin
                           dec_clr_q <= 1'b1;
                           prime_q <= 2'h0;
                        end
                        default: begin
                           prime_q <= `SDAS_PRIME_LAST;
                        end
                     endcase
                  end
               end
            end
            ST_HOLD: begin
               if (rd_result || stop_wr) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               mod_en_q <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // Status, done output and interrupt
   // ****************************************************************
   wire [`SDAS_IRQ_W-1:0] flag_set;
   wire [`SDAS_IRQ_W-1:0] flag_clr;
   wire w1c;

   assign w1c = wr_fire && wstrb_q[0] && (awaddr_q == `SDAS_ADDR_STAT);
   assign flag_set = {new_res && flag_q[`SDAS_STAT_DONE] && !rd_result, new_res};
   assign flag_clr = {w1c && wdata_q[`SDAS_STAT_OVR],
      rd_result || (w1c && wdata_q[`SDAS_STAT_DONE])};

   sdas_sticky #(
      .W(`SDAS_IRQ_W)
   ) u_flags (
      .aclk(aclk),
      .aresetn(aresetn),
      .set(flag_set),
      .clr(flag_clr),
      .flag_q(flag_q)
   );

   assign conv_done = flag_q[`SDAS_STAT_DONE];

   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flag_q & mask_q);
      end
   end

   // ****************************************************************
   // Read channel
   // ****************************************************************
   always @* begin
      rd_word = 32'h0;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `SDAS_ADDR_CTRL: begin
            rd_word[`SDAS_CTRL_MODE_HI:`SDAS_CTRL_MODE_LO] = mode_q;
            rd_word[`SDAS_CTRL_RES8] = res8_q;
            rd_word[`SDAS_CTRL_SEL_HI:`SDAS_CTRL_SEL_LO] = chan_sel_q;
         end
         `SDAS_ADDR_STAT: begin
            rd_word[`SDAS_IRQ_W-1:0] = flag_q;
            rd_word[`SDAS_STAT_BUSY] = (state_q == ST_RUN);
            rd_word[`SDAS_STAT_PRIMED] = (prime_q == `SDAS_PRIME_LAST);
         end
         `SDAS_ADDR_MASK: begin
            rd_word[`SDAS_IRQ_W-1:0] = mask_q;
         end
         `SDAS_ADDR_RSLT: begin
            rd_word[RES_W-1:0] = result_q;
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `SDAS_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `SDAS_RESP_OKAY : `SDAS_RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// ---- tb/sdas_props.sv ----
`timescale 1ns/1ns
`include "sdas_defs.vh"
module sdas_props (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire mod_en_q,
   input wire mod_rst_q,
   input wire conv_done,
   input wire irq_q
);
   // ********************
   // Checks
   // ********************
   reg [9:0] run_q;
   wire rd_res = s_axi_arvalid && s_axi_arready && s_axi_araddr == `SDAS_ADDR_RSLT;
   wire wr_idle = s_axi_awready && s_axi_wready;
   // Counts enabled cycles since the last modulator clear and holds while stopped.
   // A result needs four whole decimation periods of bits after that clear.
   always @(posedge aclk) begin
      if (!aresetn || mod_rst_q) run_q <= 10'h000;
      else if (mod_en_q && run_q != 10'h3FF) run_q <= run_q + 10'h001;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_done_hold;
      conv_done && wr_idle && !rd_res |=> conv_done;
   endproperty
   a_done_hold: assert property (p_done_hold) else $error("done fell without read");
   property p_done_clr;
      rd_res && !mod_en_q |=> !conv_done;
   endproperty
   a_done_clr: assert property (p_done_clr) else $error("done kept after read");
   property p_en_rst;
      $rose(mod_en_q) |-> mod_rst_q;
   endproperty
   a_en_rst: assert property (p_en_rst) else $error("start without clear");
   property p_rst_pulse;
      mod_rst_q |=> !mod_rst_q;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("clear pulse too long");
   property p_prime;
      $rose(conv_done) |-> $past(run_q) >= 10'd127;
   endproperty
   a_prime: assert property (p_prime) else $error("result before priming");
   property p_rlat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
   property p_blat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid;
   endproperty
   a_blat: assert property (p_blat) else $error("write answer late");
   property p_rblock;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_rblock: assert property (p_rblock) else $error("second read accepted");
   property p_refuse;
      s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0 |=>
         s_axi_rresp == `SDAS_RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_refuse: assert property (p_refuse) else $error("unaligned read not refused");
   c_done: cover property ($rose(conv_done));
   c_irq: cover property ($rose(irq_q));
   c_rst: cover property (mod_rst_q && mod_en_q);
endmodule
bind sdas_top sdas_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .mod_en_q, .mod_rst_q,
   .conv_done, .irq_q);

// ---- tb/sdas_mod_model.sv ----
`timescale 1ns/1ns
module sdas_mod_model (
   input wire aclk,
   input wire aresetn,
   input wire en,
   input wire slow,
   input wire level,
   output reg bit_q,
   output reg valid_q
);
   reg ph_q;
   // serial bitstream out
   // A slow modulator qualifies every other bit; an idle one shows a changing line.
   always @(posedge aclk) begin
      ph_q <= aresetn ? ~ph_q : 1'b0;
      valid_q <= aresetn && en && (!slow || ph_q);
      bit_q <= (aresetn && en) ? level : ~bit_q;
   end
   initial begin
      bit_q = 1'b0;
   end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`include "sdas_defs.vh"
module tb;
   reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, conv_start, level, slow, done_d;
   reg [3:0] awaddr, araddr;
   reg [31:0] wdata, rd;
   reg [1:0] rs;
   wire awready, wready, bvalid, arready, rvalid, mbit, mvalid, mod_en_q, mod_rst_q;
   wire conv_done, irq_q;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [3:0] chan_sel_q;
   integer miscompares, comparisons, since, gap, n, i, rsts;
   sdas_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .mod_bit(mbit), .mod_bit_valid(mvalid),
      .conv_start(conv_start), .mod_en_q(mod_en_q), .mod_rst_q(mod_rst_q),
      .chan_sel_q(chan_sel_q), .conv_done(conv_done), .irq_q(irq_q));
   sdas_mod_model u_mod (.aclk(aclk), .aresetn(aresetn), .en(mod_en_q), .slow(slow),
      .level(level), .bit_q(mbit), .valid_q(mvalid));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // Distance in cycles between the last two rising edges of done.
   always @(posedge aclk) begin
      done_d <= conv_done;
      if (mod_rst_q) rsts <= rsts + 1;
      if (conv_done && !done_d) begin
         gap <= since;
         since <= 1;
      end else since <= since + 1;
   end
   task end_sim;
      begin
         $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
         if (miscompares == 0 && comparisons > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   task bail;
      begin
         miscompares = miscompares + 1;
         end_sim;
      end
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         n = 0;
         rs = 2'h3;
         while (rs === 2'h3) begin
            @(posedge aclk);
            n = n + 1;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
               rs = bresp;
               bready <= 1'b0;
            end
            if (n > 50) bail;
         end
      end
   endtask
   task rdr(input [3:0] a);
      begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         n = 0;
         rs = 2'h3;
         while (rs === 2'h3) begin
            @(posedge aclk);
            n = n + 1;
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
               rd = rdata;
               rs = rresp;
               rready <= 1'b0;
            end
            if (n > 50) bail;
         end
      end
   endtask
   task wait_done;
      begin
         n = 0;
         while (conv_done !== 1'b1) begin
            @(posedge aclk);
            n = n + 1;
            if (n > 3000) bail;
         end
      end
   endtask
   task t_regs;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            rdr(4'(4 * i));
            chk("reset", 32'h0, rd);
         end
         rdr(4'h2);
         chk("rresp", `SDAS_RESP_SLVERR, rs);
         wr(4'h6, 32'h3);
         chk("bresp", `SDAS_RESP_SLVERR, rs);
         wr(`SDAS_ADDR_STAT, 32'hC);
         rdr(`SDAS_ADDR_STAT);
         chk("stat_ro", 32'h0, rd);
      end
   endtask
   task t_single;
      begin
         wr(`SDAS_ADDR_CTRL, 32'h0501);
         wait_done;
         chk("prime", 1, n >= 256);
         chk("hold_en", 0, mod_en_q);
         chk("sel", 5, chan_sel_q);
         chk("irq_masked", 0, irq_q);
         rdr(`SDAS_ADDR_STAT);
         chk("done_bit", 1, rd[0]);
         wr(`SDAS_ADDR_MASK, 32'h1);
         repeat (2) @(posedge aclk);
         chk("irq", 1, irq_q);
         rdr(`SDAS_ADDR_RSLT);
         chk("result", 32'hFFF, rd);
         chk("done_out", 0, conv_done);
         rdr(`SDAS_ADDR_STAT);
         chk("done_clr", 0, rd[0]);
         chk("irq_clr", 0, irq_q);
         repeat (300) @(posedge aclk);
         chk("standby", 0, conv_done | mod_en_q);
      end
   endtask
   task t_trig;
      begin
         slow <= 1'b1;
         wr(`SDAS_ADDR_CTRL, 32'h10);
         for (i = 0; i < 2; i = i + 1) begin
            level <= i[0];
            conv_start <= 1'b1;
            @(posedge aclk);
            conv_start <= 1'b0;
            @(posedge aclk);
            chk("trig_en", 1, mod_en_q);
            wait_done;
            chk("prime8", 1, n >= 250);
            rdr(`SDAS_ADDR_RSLT);
            chk("result8", i ? 32'hFF0 : 32'h0, rd);
         end
         slow <= 1'b0;
      end
   endtask
   task t_cont;
      begin
         wr(`SDAS_ADDR_CTRL, 32'h09);
         wait_done;
         chk("prime_c", 1, n >= 256);
         rdr(`SDAS_ADDR_RSLT);
         wait_done;
         rdr(`SDAS_ADDR_RSLT);
         chk("period", 64, gap);
         wr(`SDAS_ADDR_CTRL, 32'h02);
         repeat (4) @(posedge aclk);
         chk("stopped", 0, mod_en_q);
         rdr(`SDAS_ADDR_RSLT);
         wr(`SDAS_ADDR_STAT, 32'h3);
      end
   endtask
   task t_multi;
      begin
         for (i = 1; i < 4; i = i + 2) begin
            rsts = 0;
            wr(`SDAS_ADDR_CTRL, 32'(4 * i + 1));
            wait_done;
            rdr(`SDAS_ADDR_RSLT);
            chk("mresult", 32'hFFF, rd);
            if (i == 1) begin
               // A new selection one period into priming costs one more period.
               repeat (100) @(posedge aclk);
               wr(`SDAS_ADDR_CTRL, 32'h0104);
               rdr(`SDAS_ADDR_STAT);
               chk("unprimed", 0, rd[`SDAS_STAT_PRIMED]);
            end
            wait_done;
            chk("mod_rst", (i == 1) ? 3 : 1, rsts);
            rdr(`SDAS_ADDR_RSLT);
            chk("reprime", 1, gap >= 256);
            if (i == 1) chk("reselect", 322, gap);
            wr(`SDAS_ADDR_CTRL, 32'h02);
            repeat (4) @(posedge aclk);
            rdr(`SDAS_ADDR_RSLT);
            wr(`SDAS_ADDR_STAT, 32'h3);
            repeat (2) @(posedge aclk);
            chk("irq_w1c", 0, irq_q);
         end
      end
   endtask
   initial begin
      aresetn = 1'b0;
      awaddr = 4'h0;
      araddr = 4'h0;
      wdata = 32'h0;
      {awvalid, wvalid, bready, arvalid, rready, conv_start, slow} = 7'h00;
      level = 1'b1;
      done_d = 1'b0;
      miscompares = 0;
      comparisons = 0;
      since = 0;
      gap = 0;
      rsts = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_single;
      t_trig;
      t_cont;
      t_multi;
      end_sim;
   end
endmodule
